// ---- core/spt_pkg.sv ----
// shared constants for the stepper phase translator
package spt_pkg;
  // register offsets (apb byte addresses)
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  // control register field positions
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_HALF_BIT = 1;
  localparam int CTRL_DIR_BIT = 2;
  localparam int CTRL_COMP_BIT = 3;
  localparam int CTRL_RESET_BIT = 4;
  // control value after reset: compensation select reads high (pull-up)
  localparam logic [4:0] CTRL_RESET_VALUE = 5'h08;
  // state counter
  localparam logic [2:0] HOME_STATE = 3'h0;
  localparam logic [3:0] HOME_PATTERN = 4'h5;
  // torque level codes
  localparam logic [1:0] LEVEL_FULL = 2'h0;
  localparam logic [1:0] LEVEL_REDUCED = 2'h1;
  // percent figures of the reference levels
  localparam int LEVEL_FULL_PCT_X10 = 1000;
  localparam int LEVEL_REDUCED_PCT_X10 = 707;
  // minimum step pulse width, ns, and cycles at 40 ns
  localparam int CLK_PERIOD_NS = 40;
  localparam int STEP_PULSE_NS = 500;
  localparam int STEP_PULSE_CYCLES =
    (STEP_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : spt_pkg

// ---- core/spt_phase_rom.sv ----
// phase pattern lookup with registered output
`timescale 1ns/1ps
`default_nettype none
module spt_phase_rom (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // lookup
  input wire logic [2:0] stateIdx,
  output logic [3:0] pattern
);
  logic [3:0] patternNext;
  // eight half-step states, bit 3 winding1 fwd down to bit 0 winding2 rev
  always_comb begin
    unique case (stateIdx)
      3'h0: patternNext = 4'h5;
      3'h1: patternNext = 4'h4;
      3'h2: patternNext = 4'h6;
      3'h3: patternNext = 4'h2;
      3'h4: patternNext = 4'ha;
      3'h5: patternNext = 4'h8;
      3'h6: patternNext = 4'h9;
      3'h7: patternNext = 4'h1;
    endcase
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pattern <= spt_pkg::HOME_PATTERN;
    end else begin
      pattern <= patternNext;
    end
  end
endmodule : spt_phase_rom
`default_nettype wire

// ---- core/spt_translator.sv ----
// stepper phase translator with apb control
// Summary of operation
// R01: a control bit selects or deselects torque-ripple compensation mode.
// R02: compensated mode alternates reference between 100% and 70.7% on half steps.
// R03: compensation acts only in half-step mode; full step never alternates.
// R04: compensation select resets high, like an unconnected pulled-up pin.
// R05: half-step, normal two-phase-on and wave one-phase-on sequences are generated.
// R06: state advances once per rising edge of step, never on falling edge.
// R07: home state drives phase outputs 0101.
// R08: counter-clockwise steps the same sequence in reverse order.
// R09: reset forces 0101 outputs and returns to the first state.
// R10: direction one steps forward, zero steps in reverse.
// R11: half step moves by one; full step moves by two keeping parity.
// R12: enable low drives both block outputs and all phases low.
// R13: open-drain home indicator signals the home state.
// R14: position held in a three-bit counter; parity picks full-step variant.
// R15: reset is asynchronous and overrides any step edge; the synchronized pin reset and the soft reset act on a clock edge here.
//
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module spt_translator (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // host pins
  input wire logic stepIn,
  input wire logic translatorReset_n,
  // winding drive
  output logic winding1_fwd_drive,
  output logic winding1_rev_drive,
  output logic winding2_fwd_drive,
  output logic winding2_rev_drive,
  output logic winding1_block_n,
  output logic winding2_block_n,
  // torque reference select
  output logic [1:0] run_torque_level,
  // open-drain home indicator
  output logic homeOut,
  output logic homeOe
);
  typedef enum logic [1:0] {
    SPT_IDLE = 2'b00,
    SPT_HIGH = 2'b01,
    SPT_ARMED = 2'b11
  } spt_edge_e;

  logic [4:0] ctrl_reg;
  logic [2:0] state_reg;
  logic [2:0] state_next;
  logic [1:0] stepSync_reg;
  logic [1:0] rstSync_reg;
  logic stepPrev_reg;
  logic [1:0] level_reg;
  logic [3:0] pattern;
  logic [3:0] lowCnt_reg;
  spt_edge_e edge_reg;
  spt_edge_e edge_next;

  // apb decode
  wire logic access = psel & penable;
  wire logic hitCtrl = paddr == spt_pkg::CTRL_OFFSET;
  wire logic hitStatus = paddr == spt_pkg::STATUS_OFFSET;
  wire logic mapped = hitCtrl | hitStatus;
  wire logic ctrlWrite = access & pwrite & hitCtrl;

  wire logic enable = ctrl_reg[spt_pkg::CTRL_ENABLE_BIT];
  wire logic halfMode = ctrl_reg[spt_pkg::CTRL_HALF_BIT];
  wire logic dirFwd = ctrl_reg[spt_pkg::CTRL_DIR_BIT];
  wire logic compSel = ctrl_reg[spt_pkg::CTRL_COMP_BIT]; // [R01]
  wire logic softReset = ctrl_reg[spt_pkg::CTRL_RESET_BIT];

  // pins pass two flops, so the pin reset acts two cycles late
  // and a pulse shorter than one clock may be missed
  wire logic stepLvl = stepSync_reg[1];
  wire logic pinReset = ~rstSync_reg[1];
  wire logic anyReset = pinReset | softReset;
  // edge filter: step must stay low a minimum time before a rise counts
  wire logic lowLong = lowCnt_reg >= 4'(spt_pkg::STEP_PULSE_CYCLES);
  wire logic stepRise = stepLvl & ~stepPrev_reg & lowLong; // [R06]

  // half step moves one; full step moves two and keeps parity [R11] [R14]
  wire logic [2:0] stride = halfMode ? 3'h1 : 3'h2;
  // index 0 is home (0101): even indices are the two-phase-on states
  wire logic twoPhase = ~state_reg[0];

  always_comb begin
    state_next = state_reg;
    if (stepRise) begin
      if (dirFwd) begin
        state_next = state_reg + stride; // [R10]
      end else begin
        state_next = state_reg - stride; // [R08]
      end
    end
  end

  // torque level alternates with state parity only in half step [R02] [R03]
  wire logic [1:0] levelNext = (halfMode & compSel & twoPhase) ?
    spt_pkg::LEVEL_REDUCED : spt_pkg::LEVEL_FULL;

  always_comb begin
    edge_next = edge_reg;
    unique case (edge_reg)
      SPT_IDLE: if (!stepLvl) edge_next = SPT_HIGH;
      SPT_HIGH: if (lowLong) edge_next = SPT_ARMED;
      SPT_ARMED: if (stepLvl) edge_next = SPT_IDLE;
      default: edge_next = SPT_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_reg <= spt_pkg::CTRL_RESET_VALUE; // [R04]
    end else if (ctrlWrite) begin
      ctrl_reg <= pwdata[4:0];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stepSync_reg <= 2'h3;
      rstSync_reg <= 2'h0;
      stepPrev_reg <= 1'b1;
      lowCnt_reg <= 4'h0;
      edge_reg <= SPT_IDLE;
    end else begin
      stepSync_reg <= {stepSync_reg[0], stepIn};
      rstSync_reg <= {rstSync_reg[0], translatorReset_n};
      stepPrev_reg <= stepLvl;
      edge_reg <= edge_next;
      if (stepLvl) begin
        lowCnt_reg <= 4'h0;
      end else if (!lowLong) begin
        lowCnt_reg <= lowCnt_reg + 4'h1;
      end
    end
  end

  // reset wins over any step edge in the same cycle [R09] [R15]
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= spt_pkg::HOME_STATE;
      level_reg <= spt_pkg::LEVEL_FULL;
    end else if (anyReset) begin
      state_reg <= spt_pkg::HOME_STATE; // [R09]
      level_reg <= spt_pkg::LEVEL_FULL;
    end else begin
      state_reg <= state_next;
      level_reg <= levelNext;
    end
  end

  // sequence pattern table; even index two-phase, odd one-phase [R05]
  spt_phase_rom phaseRom (
    .clk(clk),
    .arst_n(arst_n),
    .stateIdx(state_reg),
    .pattern(pattern)
  );

  // rom lags the counter one cycle; home uses both for agreement [R07]
  wire logic atHome = (state_reg == spt_pkg::HOME_STATE) &
    (pattern == spt_pkg::HOME_PATTERN);

  // enable gates every drive output low [R12]
  assign winding1_fwd_drive = enable & pattern[3];
  assign winding1_rev_drive = enable & pattern[2];
  assign winding2_fwd_drive = enable & pattern[1];
  assign winding2_rev_drive = enable & pattern[0];
  assign winding1_block_n = enable;
  assign winding2_block_n = enable;
  assign run_torque_level = level_reg;
  // open drain: off (released) at home, pulls low elsewhere [R13]
  assign homeOut = 1'b0;
  assign homeOe = ~atHome;

  // apb answers in the access cycle, no wait states
  wire logic [31:0] statusWord = {24'h0000_00, atHome, state_reg,
    level_reg, edge_reg};
  assign pready = 1'b1;
  assign pslverr = access & ~mapped;
  assign prdata = hitCtrl ? {27'h000_0000, ctrl_reg} :
    hitStatus ? statusWord : 32'h0000_0000;
endmodule : spt_translator
`default_nettype wire

// ---- bench/spt_host_model.sv ----
// host model driving the step and reset pins
`timescale 1ns/1ps
`default_nettype none
module spt_host_model (
  // commands
  input wire logic clk,
  input wire logic doStep,
  input wire logic doRst,
  // pins
  output logic stepIn = 1'h1,
  output logic translatorReset_n
);
  assign translatorReset_n = !doRst;
  // low phase kept past the minimum so no step is lost
  always @(posedge doStep) begin
    stepIn <= 1'h0;
    repeat (14) @(posedge clk);
    stepIn <= 1'h1;
  end
endmodule : spt_host_model
`default_nettype wire

// ---- bench/spt_translator_sva.sv ----
// port assertions for the phase translator
`timescale 1ns/1ps
`default_nettype none
module spt_translator_sva (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // pins
  input wire logic stepIn,
  input wire logic translatorReset_n,
  input wire logic winding1_fwd_drive,
  input wire logic winding1_rev_drive,
  input wire logic winding2_fwd_drive,
  input wire logic winding2_rev_drive,
  input wire logic winding1_block_n,
  input wire logic winding2_block_n,
  input wire logic [1:0] run_torque_level,
  input wire logic homeOut,
  input wire logic homeOe
);
  wire logic [3:0] ph = {winding1_fwd_drive, winding1_rev_drive,
    winding2_fwd_drive, winding2_rev_drive};
  wire logic en = winding1_block_n;
  wire logic rn = translatorReset_n;
  wire logic [1:0] lv = run_torque_level;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  AST_RST: assert property ($rose(arst_n) |-> !en && !homeOe)
    else $error("not idle after reset");
  AST_OFF: assert property (!en |-> ph == 4'h0 && !winding2_block_n)
    else $error("drive while disabled");
  AST_OD: assert property (homeOut == 1'h0)
    else $error("home pin driven high");
  AST_HOME: assert property ((en && !homeOe) [*2] |-> ph == 4'h5)
    else $error("home flag off pattern");
  AST_FALL: assert property ($fell(stepIn) |=> $stable(ph) [*6])
    else $error("moved on falling edge");
  AST_RISE: assert property ($rose(stepIn) && en && rn
    |-> ##[3:6] $changed(ph)) else $error("step missed");
  // two sync flops, the counter and the table: home shows on the fifth edge
  AST_PRST: assert property ((!rn && en) [*5] |-> ph == 4'h5)
    else $error("reset not home");
  // both stable so a one-cycle skew between them is tolerated
  AST_LVL: assert property (en && lv != 2'h0 && $stable(ph)
    && $stable(lv) |-> $countones(ph) == 2) else $error("bad reduce");
  AST_ONE: assert property (en && $countones(ph) == 1 && $stable(ph)
    && $stable(lv) |-> lv == 2'h0) else $error("one phase reduced");
  C_STEP: cover property ($rose(stepIn) && en);
  C_RED: cover property (lv == 2'h1);
  C_PRST: cover property ((!rn && en) [*4]);
endmodule : spt_translator_sva
bind spt_translator spt_translator_sva i_sva (.*);
`default_nettype wire

// ---- bench/tb.sv ----
// self-checking bench for the phase translator
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin samplesChecked++; if ((a) !== (e)) begin \
  badCount++; $display("[ERR] %0t %h %h", $time, a, e); end end
module tb;
  logic clk = 1'h0, arst_n = 1'h0, psel = 1'h0, penable = 1'h0;
  logic pwrite = 1'h0, doStep = 1'h0, doRst = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, er, stepIn, translatorReset_n, homeOut, homeOe;
  logic winding1_fwd_drive, winding1_rev_drive, winding2_fwd_drive;
  logic winding2_rev_drive, winding1_block_n, winding2_block_n;
  logic [1:0] run_torque_level;
  logic [1:0] full = spt_pkg::LEVEL_FULL, red = spt_pkg::LEVEL_REDUCED;
  logic [3:0] tbl [8] = '{4'h5, 4'h4, 4'h6, 4'h2, 4'hA, 4'h8, 4'h9, 4'h1};
  wire logic [3:0] ph = {winding1_fwd_drive, winding1_rev_drive,
    winding2_fwd_drive, winding2_rev_drive};
  int badCount = 0, samplesChecked = 0, cyc = 0;
  spt_translator i_spt_translator (.*);
  spt_host_model i_spt_host_model (.*);
  initial forever #20 clk = ~clk;
  task automatic apb(input logic w, input logic [7:0] a);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    // one idle edge so a following call never drives psel twice at once
    @(posedge clk);
  endtask : apb
  // settle time covers the soft reset path
  task automatic wr(input logic [4:0] v);
    pwdata <= {27'h000_0000, v};
    apb(1'h1, spt_pkg::CTRL_OFFSET);
    repeat (6) @(posedge clk);
  endtask : wr
  task automatic stp();
    doStep <= 1'h1;
    @(posedge clk);
    doStep <= 1'h0;
    repeat (24) @(posedge clk);
  endtask : stp
  task automatic t_reset();
    apb(1'h0, spt_pkg::CTRL_OFFSET);
    `CHK(rd[4:0], spt_pkg::CTRL_RESET_VALUE)
    `CHK({ph, homeOe, winding2_block_n, homeOut}, 7'h00)
    apb(1'h0, 8'h10);
    `CHK({er, rd}, 33'h1_0000_0000)
    apb(1'h0, spt_pkg::STATUS_OFFSET);
    `CHK({er, rd}, 33'h0_0000_0080)
    $display("reset values done");
  endtask : t_reset
  task automatic t_seq();
    wr(5'h07);
    `CHK({ph, homeOe}, 5'h0A)
    for (int i = 1; i <= 8; i++) begin
      stp();
      `CHK({ph, homeOe}, {tbl[i % 8], i != 8})
    end
    wr(5'h03);
    for (int i = 1; i <= 8; i++) begin
      stp();
      `CHK(ph, tbl[(8 - i) % 8])
    end
    wr(5'h05);
    for (int i = 1; i <= 2; i++) begin
      stp();
      `CHK(ph, tbl[2 * i])
    end
    // one half step onto an odd index, then full step runs wave drive
    wr(5'h07);
    stp();
    wr(5'h05);
    stp();
    `CHK(ph, tbl[7])
    $display("sequences done");
  endtask : t_seq
  task automatic t_rst();
    doRst <= 1'h1;
    repeat (6) @(posedge clk);
    stp();
    `CHK(ph, spt_pkg::HOME_PATTERN)
    doRst <= 1'h0;
    repeat (4) @(posedge clk);
    stp();
    `CHK(ph, tbl[2])
    wr(5'h15);
    `CHK(ph, spt_pkg::HOME_PATTERN)
    $display("reset paths done");
  endtask : t_rst
  task automatic t_comp();
    wr(5'h0F);
    for (int i = 1; i <= 4; i++) begin
      stp();
      `CHK(run_torque_level, i[0] ? full : red)
    end
    wr(5'h0D);
    stp();
    `CHK({ph, run_torque_level}, {tbl[6], full})
    wr(5'h07);
    repeat (2) stp();
    `CHK(run_torque_level, full)
    wr(5'h00);
    `CHK({ph, winding1_block_n, winding2_block_n}, 6'h00)
    $display("torque and enable done");
  endtask : t_comp
  task automatic end_sim();
    $display("checks %0d bad %0d", samplesChecked, badCount);
    if (badCount == 0 && samplesChecked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      badCount++;
      end_sim();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    arst_n <= 1'h1;
    @(posedge clk);
    t_reset();
    t_seq();
    t_rst();
    t_comp();
    end_sim();
  end
endmodule : tb
`default_nettype wire
